//--- ppoc_checker.sv
// checker for port power and overcurrent outputs
`timescale 1ns/10ps
`default_nettype none
module ppoc_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cfgLoad,
  input wire logic cpuSelect,
  input wire logic [5:0] hubPowerEn,
  input wire logic [5:0] cpuPowerEn,
  input wire logic [5:0] hubOcAck,
  input wire logic [5:0] cpuOcAck,
  input wire logic [5:0] portPowerSensePinsOut,
  input wire logic [5:0] portPowerSensePinsOe,
  input wire logic [5:0] portPullUpEn,
  input wire logic sharedPowerSensePinOut,
  input wire logic sharedPowerSensePinOe,
  input wire logic sharedPullUpEn,
  input wire logic [5:0] ocFlag,
  input wire logic gangedMode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // power request and acknowledge of the selected controller
  wire [5:0] pw = cpuSelect ? cpuPowerEn : hubPowerEn;
  wire [5:0] ak = cpuSelect ? cpuOcAck : hubOcAck;
  property p_oe;
    !gangedMode && $past(!gangedMode) |->
      portPowerSensePinsOe == ~$past(pw);
  endproperty
  a_oe: assert property (p_oe) else $error("pin drive wrong");
  property p_pu;
    !gangedMode && $past(!gangedMode) |->
      portPullUpEn == ~portPowerSensePinsOe;
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up wrong");
  property p_out;
    portPowerSensePinsOut == 6'h00;
  endproperty
  a_out: assert property (p_out) else $error("pin not low");
  property p_gang;
    gangedMode && $past(gangedMode) |-> portPowerSensePinsOe == 6'h3F;
  endproperty
  a_gang: assert property (p_gang) else $error("port pins free");
  property p_shr;
    !gangedMode && $past(!gangedMode) |-> sharedPowerSensePinOe;
  endproperty
  a_shr: assert property (p_shr) else $error("shared pin free");
  property p_mode;
    $changed(gangedMode) |-> $past(cfgLoad, 2);
  endproperty
  a_mode: assert property (p_mode) else $error("mode moved");
  property p_all;
    gangedMode && $past(ocFlag) == 6'h00 && ocFlag != 6'h00 |->
      ocFlag == 6'h3F;
  endproperty
  a_all: assert property (p_all) else $error("partial flags");
  property p_hold;
    (ocFlag & $past(ocFlag & ~ak)) == $past(ocFlag & ~ak);
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
  property p_spu;
    sharedPullUpEn == !sharedPowerSensePinOe;
  endproperty
  a_spu: assert property (p_spu) else $error("shared pull-up wrong");
  property p_sout;
    sharedPowerSensePinOut == 1'b0;
  endproperty
  a_sout: assert property (p_sout) else $error("shared pin not low");
endmodule // ppoc_checker
`default_nettype wire

//--- ppoc_map.vh
// port count, defaults and timing counts for the port power and overcurrent block
`ifndef PPOC_MAP_VH
`define PPOC_MAP_VH
`define PPOC_CLK_HZ 10000000
`define PPOC_MS_CYCLES 14'h2710
`define PPOC_MS_CYC_W 14
`define PPOC_NPORTS 6
`define PPOC_WIDTH_DEF 4'h5
`define PPOC_WIDTH_MAX 4'h5
`define PPOC_WINDOW_DEF 8'h14
`define PPOC_LOCKOUT_DEF 8'h0A
`endif

//--- ppoc_port_ctrl.v
// port power enable and overcurrent sense over shared pins, six ports
//
// Contract
// - After reset, individual mode unless ganged mode is configured.
// - Individual mode: one independent power/sense pin per downstream port.
// - Ganged mode chosen only by SMBus or OTP configuration load.
// - Ganged mode: one shared pin switches and senses all ports.
// - Ganged overcurrent flags every downstream port at once.
// - Power off: drive pin low, pull-up off.
// - Power on: low driver off, pull-up on, pin is open drain.
// - Switch pulls pin low on overcurrent; low on enabled pin means overcurrent.
// - Filter sense input so power-up transients give no false reports.
// - Charging supply indication configurable per port pin, six pins.
// - Power and overcurrent driven by hub logic or embedded processor.
// - Continuous low for 0 to 5 ms (default 5) reports overcurrent.
// - Two low groups within rolling window (default 20 ms) report overcurrent.
// - Ignore sense for lockout period after power on, default 10 ms.
`timescale 1ns/10ps
`default_nettype none
`include "ppoc_map.vh"
module ppoc_port_ctrl (
  input wire clk_sys,
  input wire rst_n,
  input wire cfgLoad,
  input wire cfgGanged,
  input wire [5:0] cfgChargeEn,
  input wire [3:0] cfgMinWidth,
  input wire [7:0] cfgWindowMs,
  input wire [7:0] cfgLockoutMs,
  input wire cpuSelect,
  input wire [5:0] hubPowerEn,
  input wire [5:0] cpuPowerEn,
  input wire [5:0] hubOcAck,
  input wire [5:0] cpuOcAck,
  input wire [5:0] portPowerSensePinsIn,
  output reg [5:0] portPowerSensePinsOut,
  output reg [5:0] portPowerSensePinsOe,
  output reg [5:0] portPullUpEn,
  input wire sharedPowerSensePinIn,
  output reg sharedPowerSensePinOut,
  output reg sharedPowerSensePinOe,
  output reg sharedPullUpEn,
  output reg [5:0] ocFlag,
  output reg [5:0] chargeIndicate,
  output reg gangedMode
);
  reg [13:0] divCnt_q;
  reg msTick_q;
  reg gang_q;
  reg [5:0] chargeCfg_q;
  reg [3:0] minWidth_q;
  reg [7:0] windowMs_q;
  reg [7:0] lockoutMs_q;
  reg [5:0] syncA_q;
  reg [5:0] syncB_q;
  reg gSyncA_q;
  reg gSyncB_q;
  reg [5:0] powerEn;
  reg [5:0] ocAck;
  wire [5:0] ocEvent;
  wire gangOcEvent;
  wire gangPower;
  // 1 ms enable pulse from the system clock
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= 14'h0000;
      msTick_q <= 1'b0;
    end else if (divCnt_q == `PPOC_MS_CYCLES - 14'h0001) begin
      divCnt_q <= 14'h0000;
      msTick_q <= 1'b1;
    end else begin
      divCnt_q <= divCnt_q + 14'h0001;
      msTick_q <= 1'b0;
    end
  end
  // configuration taken only on a configuration load strobe
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gang_q <= 1'b0;
      chargeCfg_q <= 6'h00;
      minWidth_q <= `PPOC_WIDTH_DEF;
      windowMs_q <= `PPOC_WINDOW_DEF;
      lockoutMs_q <= `PPOC_LOCKOUT_DEF;
    end else if (cfgLoad) begin
      gang_q <= cfgGanged;
      chargeCfg_q <= cfgChargeEn;
      minWidth_q <= cfgMinWidth;
      windowMs_q <= cfgWindowMs;
      lockoutMs_q <= cfgLockoutMs;
    end
  end
  // control source: hub logic or embedded processor
  always @* begin
    powerEn = cpuSelect ? cpuPowerEn : hubPowerEn;
    ocAck = cpuSelect ? cpuOcAck : hubOcAck;
  end
  assign gangPower = |powerEn;
  // two-stage synchronisers for every sense pin
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= 6'h3F;
      syncB_q <= 6'h3F;
      gSyncA_q <= 1'b1;
      gSyncB_q <= 1'b1;
    end else begin
      syncA_q <= portPowerSensePinsIn;
      syncB_q <= syncA_q;
      gSyncA_q <= sharedPowerSensePinIn;
      gSyncB_q <= gSyncA_q;
    end
  end
  // one filter per port, fed only in individual mode
  genvar i;
  generate
    for (i = 0; i < `PPOC_NPORTS; i = i + 1) begin : gPort
      ppoc_sense_filter uFilt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .msTick(msTick_q),
        .powerOn(powerEn[i] && !gang_q),
        .senseLow(!syncB_q[i]),
        .minWidth(minWidth_q),
        .windowMs(windowMs_q),
        .lockoutMs(lockoutMs_q),
        .ocEvent(ocEvent[i])
      );
    end
  endgenerate
  // filter for the shared pin in ganged mode
  ppoc_sense_filter uGangFilt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .msTick(msTick_q),
    .powerOn(gangPower && gang_q),
    .senseLow(!gSyncB_q),
    .minWidth(minWidth_q),
    .windowMs(windowMs_q),
    .lockoutMs(lockoutMs_q),
    .ocEvent(gangOcEvent)
  );
  // sticky flags; a new event wins over an acknowledge
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ocFlag <= 6'h00;
    end else if (gang_q) begin
      ocFlag <= (ocFlag & ~ocAck) | {6{gangOcEvent}};
    end else begin
      ocFlag <= (ocFlag & ~ocAck) | ocEvent;
    end
  end
  // pin drive: low while off, released with pull-up while on
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      portPowerSensePinsOut <= 6'h00;
      portPowerSensePinsOe <= 6'h3F;
      portPullUpEn <= 6'h00;
      sharedPowerSensePinOut <= 1'b0;
      sharedPowerSensePinOe <= 1'b1;
      sharedPullUpEn <= 1'b0;
      chargeIndicate <= 6'h00;
      gangedMode <= 1'b0;
    end else begin
      portPowerSensePinsOut <= 6'h00;
      if (gang_q) begin
        portPowerSensePinsOe <= 6'h3F;
        portPullUpEn <= 6'h00;
      end else begin
        portPowerSensePinsOe <= ~powerEn;
        portPullUpEn <= powerEn;
      end
      sharedPowerSensePinOut <= 1'b0;
      sharedPowerSensePinOe <= !(gang_q && gangPower);
      sharedPullUpEn <= gang_q && gangPower;
      chargeIndicate <= chargeCfg_q & powerEn;
      gangedMode <= gang_q;
    end
  end
endmodule // ppoc_port_ctrl
`default_nettype wire

//--- ppoc_port_ctrl_tb.sv
// testbench for the port power and overcurrent block
`timescale 1ns/10ps
`default_nettype none
module ppoc_port_ctrl_tb;
  logic clk_sys = 1'b0, rst_n = 1'b0, cfgLoad = 1'b0, gang = 1'b0;
  logic cpuSel = 1'b0;
  logic [5:0] hubPw = 6'h00, cpuPw = 6'h00, ack = 6'h00, pw;
  logic [5:0] chg = 6'h00, cpuAck = 6'h00;
  logic [5:0] expQ[$];
  logic [3:0] wid = 4'h5;
  logic [7:0] lck = 8'h02, win = 8'h02;
  // reference model state, kept from the rules
  integer mGang = 0, mChg = 0, mFlag = 0;
  logic [6:0] fault = 7'h00;
  wire [6:0] lvl;
  wire [5:0] pOut, pOe, pPu, ocFlag, chgInd;
  wire sOut, sOe, sPu, gm;
  integer seed = 23260, bad_count = 0, compares = 0, cycles = 0, i;
  ppoc_port_ctrl ppoc_port_ctrl_i (.clk_sys, .rst_n, .cfgLoad,
    .cfgGanged(gang), .cfgChargeEn(chg), .cfgMinWidth(wid),
    .cfgWindowMs(win), .cfgLockoutMs(lck), .cpuSelect(cpuSel),
    .hubPowerEn(hubPw), .cpuPowerEn(cpuPw), .hubOcAck(ack),
    .cpuOcAck(cpuAck), .portPowerSensePinsIn(lvl[5:0]),
    .portPowerSensePinsOut(pOut), .portPowerSensePinsOe(pOe),
    .portPullUpEn(pPu), .sharedPowerSensePinIn(lvl[6]),
    .sharedPowerSensePinOut(sOut), .sharedPowerSensePinOe(sOe),
    .sharedPullUpEn(sPu), .ocFlag, .chargeIndicate(chgInd),
    .gangedMode(gm));
  ppoc_power_switch ppoc_power_switch_i (.clk_sys, .en({sOe, pOe}),
    .val({sOut, pOut}), .pu({sPu, pPu}), .fault, .lvl);
  always #50 clk_sys = ~clk_sys;
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask
  // model: queue expected pin drive, pull-up and charge words
  task automatic push_pins(input logic [5:0] p);
    expQ.push_back(mGang ? 6'h3F : ~p);
    expQ.push_back(mGang ? 6'h00 : p);
    expQ.push_back(6'(mChg) & p);
  endtask
  // acknowledge pulse from hub logic or processor
  task automatic ackp(input logic [5:0] m, input logic viaCpu);
    if (viaCpu) cpuAck = m;
    else ack = m;
    cyc(1);
    ack = 6'h00;
    cpuAck = 6'h00;
    cyc(2);
    if (viaCpu == cpuSel) mFlag = mFlag & ~m;
  endtask
  task automatic low(input logic [6:0] m, input integer n);
    fault = m;
    cyc(n);
    fault = 7'h00;
    cyc(10);
  endtask
  task automatic load(input logic g, input logic [3:0] w, input logic [7:0] l);
    gang = g;
    wid = w;
    lck = l;
    cfgLoad = 1'b1;
    cyc(1);
    cfgLoad = 1'b0;
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      test_done;
    end
  end
  // main sequence
  initial begin
    cyc(16);
    rst_n = 1'b1;
    chk(pOe, 6'h3F);
    chk({5'h00, gm}, 6'h00);
    chg = 6'($random(seed));
    mChg = chg;
    load(1'b0, 4'h5, 8'h02);
    for (i = 0; i < 200; i++) begin
      {hubPw, cpuPw, cpuSel} = 13'($random(seed));
      pw = cpuSel ? cpuPw : hubPw;
      push_pins(pw);
      cyc(1);
      chk(pOe, expQ.pop_front());
      chk(pPu, expQ.pop_front());
      chk(chgInd, expQ.pop_front());
      chk(ocFlag, 6'(mFlag));
    end
    cpuSel = 1'b0;
    hubPw = 6'h00;
    cyc(2);
    hubPw = 6'h01;
    cyc(3000);
    low(7'h01, 2000);
    cyc(17000);
    low(7'h01, 2000);
    chk(ocFlag, 6'(mFlag));
    cyc(3000);
    low(7'h01, 2000);
    mFlag = 1;
    chk(ocFlag, 6'(mFlag));
    cyc(500);
    chk(ocFlag, 6'(mFlag));
    ackp(6'h01, 1'b0);
    chk(ocFlag, 6'(mFlag));
    // single long low with a 1 ms width, then groups too far apart
    win = 8'h01;
    load(1'b0, 4'h1, 8'h02);
    low(7'h01, 12000);
    mFlag = 1;
    chk(ocFlag, 6'(mFlag));
    ackp(6'h01, 1'b0);
    load(1'b0, 4'h5, 8'h02);
    low(7'h01, 200);
    cyc(12000);
    low(7'h01, 200);
    chk(ocFlag, 6'(mFlag));
    hubPw = 6'h00;
    load(1'b1, 4'h0, 8'h01);
    mGang = 1;
    hubPw = 6'h08;
    push_pins(hubPw);
    cyc(2);
    chk(pOe, expQ.pop_front());
    chk(pPu, expQ.pop_front());
    chk(chgInd, expQ.pop_front());
    chk({5'h00, gm}, 6'h01);
    chk({sOe, pOe[4:0]}, 6'h1F);
    chk({4'h0, sPu, sOut}, 6'h02);
    cyc(11000);
    low(7'h40, 20);
    mFlag = 63;
    chk(ocFlag, 6'(mFlag));
    // processor in control: hub acknowledge ignored, its own clears
    cpuSel = 1'b1;
    ackp(6'h3F, 1'b0);
    chk(ocFlag, 6'(mFlag));
    ackp(6'h3F, 1'b1);
    chk(ocFlag, 6'(mFlag));
    test_done;
  end
endmodule // ppoc_port_ctrl_tb
bind ppoc_port_ctrl ppoc_checker ppoc_checker_i (.clk_sys, .rst_n,
  .cfgLoad, .cpuSelect, .hubPowerEn, .cpuPowerEn, .hubOcAck, .cpuOcAck,
  .portPowerSensePinsOut, .portPowerSensePinsOe, .portPullUpEn,
  .sharedPowerSensePinOut, .sharedPowerSensePinOe, .sharedPullUpEn,
  .ocFlag, .gangedMode);
`default_nettype wire

//--- ppoc_power_switch.sv
// external power switch model on six port pins and the shared pin
`timescale 1ns/10ps
`default_nettype none
module ppoc_power_switch (
  input wire logic clk_sys,
  input wire logic [6:0] en,
  input wire logic [6:0] val,
  input wire logic [6:0] pu,
  input wire logic [6:0] fault,
  output logic [6:0] lvl
);
  logic tog = 1'b0;
  // a floating pin wanders
  always @(posedge clk_sys) tog <= ~tog;
  // device drive first, then switch fault, then pull-up
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      lvl[i] = en[i] ? val[i] : fault[i] ? 1'b0 : pu[i] ? 1'b1 : tog;
    end
  end
endmodule // ppoc_power_switch
`default_nettype wire

//--- ppoc_sense_filter.v
// one port's overcurrent sense filter: lockout, single and double low pulse
`timescale 1ns/10ps
`default_nettype none
`include "ppoc_map.vh"
module ppoc_sense_filter (
  input wire clk_sys,
  input wire rst_n,
  input wire msTick,
  input wire powerOn,
  input wire senseLow,
  input wire [3:0] minWidth,
  input wire [7:0] windowMs,
  input wire [7:0] lockoutMs,
  output reg ocEvent
);
  localparam ST_OFF = 2'h0;
  localparam ST_LOCK = 2'h1;
  localparam ST_RUN = 2'h2;
  reg [1:0] state_q;
  reg [7:0] msCnt_q;
  reg [3:0] lowMs_q;
  reg [7:0] winMs_q;
  reg winActive_q;
  reg prevLow_q;
  reg [3:0] widthEff;
  wire groupStart;
  // width setting above five is clamped to five
  always @* begin
    widthEff = (minWidth > `PPOC_WIDTH_MAX) ? `PPOC_WIDTH_MAX : minWidth;
  end
  assign groupStart = senseLow && !prevLow_q;
  // lockout, then continuous-low and two-group window checks
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
      msCnt_q <= 8'h00;
      lowMs_q <= 4'h0;
      winMs_q <= 8'h00;
      winActive_q <= 1'b0;
      prevLow_q <= 1'b0;
      ocEvent <= 1'b0;
    end else begin
      ocEvent <= 1'b0;
      case (state_q)
        ST_OFF: begin
          prevLow_q <= 1'b0;
          winActive_q <= 1'b0;
          lowMs_q <= 4'h0;
          msCnt_q <= 8'h00;
          if (powerOn) begin
            state_q <= ST_LOCK;
          end
        end
        ST_LOCK: begin
          // sense ignored right after power on
          if (!powerOn) begin
            state_q <= ST_OFF;
          end else if (msTick) begin
            msCnt_q <= msCnt_q + 8'h01;
            if (msCnt_q + 8'h01 >= lockoutMs) begin
              state_q <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          prevLow_q <= senseLow;
          if (!powerOn) begin
            state_q <= ST_OFF;
          end else begin
            // single continuous low pulse
            if (!senseLow) begin
              lowMs_q <= 4'h0;
            end else if (lowMs_q >= widthEff) begin
              ocEvent <= 1'b1;
            end else if (msTick) begin
              lowMs_q <= lowMs_q + 4'h1;
            end
            // two low groups within the rolling window
            if (groupStart) begin
              if (winActive_q) begin
                ocEvent <= 1'b1;
                winActive_q <= 1'b0;
              end else begin
                winActive_q <= 1'b1;
                winMs_q <= 8'h00;
              end
            end else if (winActive_q && msTick) begin
              winMs_q <= winMs_q + 8'h01;
              if (winMs_q + 8'h01 >= windowMs) begin
                winActive_q <= 1'b0;
              end
            end
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end
endmodule // ppoc_sense_filter
`default_nettype wire
